// File: src/mgc_ctrl.sv
// global control, external alarm and desync reset indication logic
// assumes sys_clk at 125 MHz; pins and alarm clocks arrive asynchronous
`timescale 1ns/1ps
// Function
// R1 - ds3 alarm clock at 44.736 MHz
// R2 - ds3 prbs falls back to alarm clock
// R3 - e3 alarm clock at 34.368 MHz
// R4 - e3 prbs falls back to alarm clock
// R5 - timing select high: independent bus timing
// R6 - timing select low: add timed by drop
// R7 - reset low clears, presets, floats outputs
// R8 - reset held low 200 ns, clocks running
// R9 - routing enabled path alarm sets flag
// R10 - routing enabled ignores in-band e1 ais
// R11 - sonet alarm input sets its flag
// R12 - float control low tristates all outputs
// R13 - reset indication high 125 to 250 us
// R14 - four events trigger reset indication
module mgc_ctrl
  import mgc_pkg::*;
#(
  parameter int unsigned CH = MGC_CHANNELS,
  parameter int unsigned DFR_CYC = MGC_DFR_CYC,
  parameter int unsigned LOSS_CYC = MGC_CLK_LOSS_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic hw_reset_n,
  input wire logic float_ctrl_n,
  input wire logic add_side_timing_select,
  input wire logic ds3_alarm_clock,
  input wire logic e3_alarm_clock,
  input wire logic ds3_mode,
  input wire logic tx_line_clk_present,
  input wire logic rx_line_clk_present,
  input wire logic alarm_routing_enable,
  input wire logic global_soft_reset,
  input wire logic [CH-1:0] channel_soft_reset,
  input wire logic [CH-1:0] fifo_slip,
  input wire logic [CH-1:0] path_alarm_input,
  input wire logic [CH-1:0] external_sonet_alarm_input,
  input wire logic [CH-1:0] inband_ais,
  input wire logic [CH-1:0] flag_clear,
  output logic [CH-1:0] ext_path_alarm_flag,
  output logic [CH-1:0] ext_sonet_alarm_flag,
  output logic [CH-1:0] upstream_ais,
  output logic [CH-1:0] desync_fifo_reset_flag,
  output logic [CH-1:0] desync_fifo_reset_flag_oe,
  output logic ds3_ais_clock_ok,
  output logic e3_ais_clock_ok,
  output logic tx_prbs_use_alarm_clk,
  output logic rx_prbs_use_alarm_clk,
  output logic add_timing_from_drop,
  output logic internal_reset,
  output logic outputs_float
);
  localparam int unsigned DW = $clog2(DFR_CYC + 1);
  localparam int unsigned LW = $clog2(LOSS_CYC + 1);
  localparam logic [DW-1:0] DFR_LOAD = DW'(DFR_CYC);
  localparam logic [LW-1:0] LOSS_LOAD = LW'(LOSS_CYC);

  // two-flop synchronisers for the pin inputs; channel_soft_reset, flag_clear and inband_ais enter unsynchronised
  localparam int unsigned NS = 3 * CH + 11;
  logic [NS-1:0] s1_q, s2_q, s3_q;
  logic [NS-1:0] pins;
  assign pins = {path_alarm_input, external_sonet_alarm_input, fifo_slip,
                 hw_reset_n, float_ctrl_n, add_side_timing_select,
                 ds3_alarm_clock, e3_alarm_clock, tx_line_clk_present,
                 rx_line_clk_present, ds3_mode, alarm_routing_enable,
                 global_soft_reset, 1'b0};
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  logic [CH-1:0] pa_s, sa_s, slip_s;
  logic hrst_n_s, flt_n_s, tsel_s, dclk_s, eclk_s, txp_s, rxp_s, ds3_s;
  logic route_s, gsr_s, dclk_p, eclk_p, unused_s;
  assign {pa_s, sa_s, slip_s, hrst_n_s, flt_n_s, tsel_s, dclk_s, eclk_s,
          txp_s, rxp_s, ds3_s, route_s, gsr_s, unused_s} = s2_q;
  // third-flop copies of alarm clocks and hw reset, for edge detection
  assign dclk_p = s3_q[7];
  assign eclk_p = s3_q[6];
  logic hrst_n_p;
  assign hrst_n_p = s3_q[10];

  // hardware reset low: internal reset and float
  assign internal_reset = srst | ~hrst_n_s; // R7
  // timing mode follows the select pin
  assign add_timing_from_drop = ~tsel_s; // R5 R6
  // float control low, or hw reset low, tristates outputs
  assign outputs_float = ~flt_n_s | ~hrst_n_s; // R12 R7

  // alarm clock presence watchdogs; edge seen on synced copy
  logic [LW-1:0] dwd_q, ewd_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dwd_q <= '0;
    end else if (dclk_s != dclk_p) begin
      dwd_q <= LOSS_LOAD;
    end else if (dwd_q != '0) begin
      dwd_q <= dwd_q - LW'(1);
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ewd_q <= '0;
    end else if (eclk_s != eclk_p) begin
      ewd_q <= LOSS_LOAD;
    end else if (ewd_q != '0) begin
      ewd_q <= ewd_q - LW'(1);
    end
  end
  // without the alarm clock no ais can be generated
  assign ds3_ais_clock_ok = (dwd_q != '0); // R1
  assign e3_ais_clock_ok = (ewd_q != '0); // R3

  // prbs backup: fall back when line clock absent and alarm clock runs
  always_comb begin
    if (ds3_s) begin
      tx_prbs_use_alarm_clk = ~txp_s & ds3_ais_clock_ok; // R2
      rx_prbs_use_alarm_clk = ~rxp_s & ds3_ais_clock_ok; // R2
    end else begin
      tx_prbs_use_alarm_clk = ~txp_s & e3_ais_clock_ok; // R4
      rx_prbs_use_alarm_clk = ~rxp_s & e3_ais_clock_ok; // R4
    end
  end

  // per-channel flags and desync reset pulse
  logic hrst_fall;
  assign hrst_fall = hrst_n_p & ~hrst_n_s;
  logic gsr_p_q;
  logic [CH-1:0] csr_p_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      gsr_p_q <= 1'b0;
      csr_p_q <= '0;
    end else begin
      gsr_p_q <= gsr_s;
      csr_p_q <= channel_soft_reset;
    end
  end
  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_ch
      logic pflag_q, sflag_q;
      logic [DW-1:0] dcnt_q;
      logic trig;
      // set wins over clear; hw reset clears the flags
      always_ff @(posedge sys_clk) begin
        if (internal_reset) begin
          pflag_q <= MGC_FLAG_RST; // R7
        end else if (route_s && pa_s[g]) begin
          pflag_q <= 1'b1; // R9
        end else if (flag_clear[g]) begin
          pflag_q <= 1'b0;
        end
      end
      always_ff @(posedge sys_clk) begin
        if (internal_reset) begin
          sflag_q <= MGC_FLAG_RST; // R7
        end else if (sa_s[g]) begin
          sflag_q <= 1'b1; // R11
        end else if (flag_clear[g]) begin
          sflag_q <= 1'b0;
        end
      end
      assign ext_path_alarm_flag[g] = pflag_q;
      assign ext_sonet_alarm_flag[g] = sflag_q;
      // in-band ais masked while routed to pin
      assign upstream_ais[g] = route_s ? pflag_q : inband_ais[g]; // R10
      // any of four events restarts the pulse
      assign trig = hrst_fall | (gsr_s & ~gsr_p_q) |
                    (channel_soft_reset[g] & ~csr_p_q[g]) | slip_s[g]; // R14
      // counter survives hw reset so the reset pulse itself is seen
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          dcnt_q <= '0;
        end else if (trig) begin
          dcnt_q <= DFR_LOAD; // R13
        end else if (dcnt_q != '0) begin
          dcnt_q <= dcnt_q - DW'(1); // R13
        end
      end
      assign desync_fifo_reset_flag[g] = (dcnt_q != '0); // R13
      assign desync_fifo_reset_flag_oe[g] = ~outputs_float; // R12
    end
  endgenerate
endmodule : mgc_ctrl

// File: src/mgc_pkg.sv
// package for the mapper global control and alarm block
// assumes a single 125 MHz system clock domain
package mgc_pkg;
  localparam int unsigned MGC_CLK_MHZ = 125;
  localparam int unsigned MGC_CHANNELS = 3;
  // hardware reset least low time, ns
  localparam int unsigned MGC_HRST_MIN_NS = 200;
  // desync fifo reset indication window, us
  localparam int unsigned MGC_DFR_MIN_US = 125;
  localparam int unsigned MGC_DFR_MAX_US = 250;
  localparam int unsigned MGC_DFR_MIN_CYC = MGC_DFR_MIN_US * MGC_CLK_MHZ;
  localparam int unsigned MGC_DFR_MAX_CYC = MGC_DFR_MAX_US * MGC_CLK_MHZ;
  // pulse lands mid window for margin
  localparam int unsigned MGC_DFR_CYC = (MGC_DFR_MIN_CYC + MGC_DFR_MAX_CYC) / 2;
  // clock presence watchdog: system cycles with no edge means absent
  localparam int unsigned MGC_CLK_LOSS_CYC = 16;
  localparam logic MGC_FLAG_RST = 1'b0;
  localparam logic MGC_ROUTE_RST = 1'b0;
  localparam int unsigned MGC_PATH_FLAG_BIT = 0;
  localparam int unsigned MGC_SONET_FLAG_BIT = 1;
  localparam int unsigned MGC_ROUTE_BIT = 7;
  localparam int unsigned MGC_GSOFT_BIT = 0;
endpackage : mgc_pkg

// File: sim/mgc_board.sv
// board model: alarm clock sources
// assumes the design samples alarm clocks as data on sys_clk
`timescale 1ns/1ps
module mgc_board (
  input wire logic run,
  output logic ds3_alarm_clock,
  output logic e3_alarm_clock
);
  // rates scaled down: must stay below half of sys_clk
  initial ds3_alarm_clock = 1'h0;
  initial e3_alarm_clock = 1'h0;
  always #22.368 if (run) ds3_alarm_clock = ~ds3_alarm_clock;
  always #29.184 if (run) e3_alarm_clock = ~e3_alarm_clock;
endmodule : mgc_board

// File: sim/mgc_ctrl_sva.sv
// port checker for mgc_ctrl
// assumes one clock domain, srst synchronous
`timescale 1ns/1ps
module mgc_chk
  import mgc_pkg::*;
#(parameter int unsigned CH = 3) (
  input wire logic sys_clk, srst, hw_reset_n, float_ctrl_n,
  input wire logic add_side_timing_select, alarm_routing_enable,
  input wire logic add_timing_from_drop, internal_reset, outputs_float,
  input wire logic [CH-1:0] channel_soft_reset, path_alarm_input,
  input wire logic [CH-1:0] external_sonet_alarm_input,
  input wire logic [CH-1:0] ext_path_alarm_flag, ext_sonet_alarm_flag,
  input wire logic [CH-1:0] upstream_ais, desync_fifo_reset_flag,
  input wire logic [CH-1:0] desync_fifo_reset_flag_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // five cycles cover two sync flops plus the flag register
  path_flag_a: assert property ((alarm_routing_enable && path_alarm_input[0]
    && hw_reset_n)[*5] |-> ext_path_alarm_flag[0]) else $error("path flag");
  sonet_flag_a: assert property ((external_sonet_alarm_input[1] && hw_reset_n)
    [*5] |-> ext_sonet_alarm_flag[1]) else $error("sonet flag");
  route_ais_a: assert property (alarm_routing_enable[*3] |->
    upstream_ais == ext_path_alarm_flag) else $error("inband used");
  pulse_min_a: assert property ($rose(desync_fifo_reset_flag[0]) |->
    desync_fifo_reset_flag[0][*8]) else $error("pulse short");
  float_all_a: assert property (!float_ctrl_n[*3] |-> outputs_float &&
    !desync_fifo_reset_flag_oe) else $error("no float");
  hw_reset_a: assert property (!hw_reset_n[*3] |-> internal_reset &&
    outputs_float) else $error("reset ignored");
  timing_sel_a: assert property (add_side_timing_select[*3] |->
    !add_timing_from_drop) else $error("timing mode");
  soft_trig_a: assert property ($rose(channel_soft_reset[2]) |-> ##1
    desync_fifo_reset_flag[2]) else $error("no pulse");
  cover property ($rose(desync_fifo_reset_flag[2]));
  cover property ($rose(ext_path_alarm_flag[0]));
  cover property ($rose(outputs_float));
endmodule : mgc_chk
bind mgc_ctrl mgc_chk #(.CH(CH)) u_chk (.*);

// File: sim/tb.sv
// testbench for mgc_ctrl, desync pulse shortened to 20 cycles
// assumes mgc_board supplies the alarm clocks
`timescale 1ns/1ps
module tb;
  import mgc_pkg::*;
  logic sys_clk = 1'h0, srst = 1'h1, hw_reset_n = 1'h1, float_ctrl_n = 1'h1;
  logic add_side_timing_select = 1'h1, ds3_mode = 1'h1, run = 1'h1;
  logic tx_line_clk_present = 1'h1, rx_line_clk_present = 1'h1;
  logic alarm_routing_enable = 1'h0, global_soft_reset = 1'h0;
  logic [2:0] channel_soft_reset = 3'h0, fifo_slip = 3'h0, flag_clear = 3'h0;
  logic [2:0] path_alarm_input = 3'h0, external_sonet_alarm_input = 3'h0;
  logic [2:0] inband_ais = 3'h4, ext_path_alarm_flag, ext_sonet_alarm_flag;
  logic [2:0] upstream_ais, desync_fifo_reset_flag, desync_fifo_reset_flag_oe;
  logic ds3_alarm_clock, e3_alarm_clock, ds3_ais_clock_ok, e3_ais_clock_ok;
  logic tx_prbs_use_alarm_clk, rx_prbs_use_alarm_clk, add_timing_from_drop;
  logic internal_reset, outputs_float;
  logic [7:0] n;
  int n_mismatch = 0, tests_run = 0;
  always #4 sys_clk = ~sys_clk;
  mgc_ctrl #(.DFR_CYC(20)) DUT (.*);
  mgc_board u_board (.run(run), .ds3_alarm_clock(ds3_alarm_clock),
    .e3_alarm_clock(e3_alarm_clock));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : cyc
  task close_out;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task t_alarm;
    path_alarm_input = 3'h1;
    external_sonet_alarm_input = 3'h2;
    cyc(6);
    chk(ext_path_alarm_flag, 8'h0);
    chk(ext_sonet_alarm_flag, 8'h2);
    chk(upstream_ais, 8'h4);
    alarm_routing_enable = 1'h1;
    cyc(6);
    chk(ext_path_alarm_flag, 8'h1);
    chk(upstream_ais, 8'h1);
    path_alarm_input = 3'h0;
    external_sonet_alarm_input = 3'h0;
    flag_clear = 3'h7;
    cyc(4);
    flag_clear = 3'h0;
    chk({ext_path_alarm_flag, ext_sonet_alarm_flag}, 8'h0);
  endtask : t_alarm
  task t_pulse;
    global_soft_reset = 1'h1;
    cyc(5);
    chk(desync_fifo_reset_flag, 8'h7);
    global_soft_reset = 1'h0;
    cyc(25);
    fifo_slip = 3'h2;
    cyc(5);
    fifo_slip = 3'h0;
    chk(desync_fifo_reset_flag, 8'h2);
    cyc(25);
    channel_soft_reset = 3'h4;
    cyc(1);
    channel_soft_reset = 3'h0;
    n = 8'h0;
    while (desync_fifo_reset_flag[2] === 1'h1 && n < 8'h64) begin
      n++;
      cyc(1);
    end
    chk(n, 8'h14);
  endtask : t_pulse
  task t_hrst;
    external_sonet_alarm_input = 3'h1;
    cyc(6);
    external_sonet_alarm_input = 3'h0;
    hw_reset_n = 1'h0;
    cyc(4);
    chk(desync_fifo_reset_flag, 8'h7);
    cyc(22);
    chk({internal_reset, outputs_float}, 8'h3);
    chk(ext_sonet_alarm_flag, 8'h0);
    hw_reset_n = 1'h1;
    cyc(4);
    chk({internal_reset, outputs_float}, 8'h0);
  endtask : t_hrst
  task t_mode;
    float_ctrl_n = 1'h0;
    cyc(4);
    chk({outputs_float, desync_fifo_reset_flag_oe}, 8'h8);
    float_ctrl_n = 1'h1;
    add_side_timing_select = 1'h0;
    cyc(4);
    chk({add_timing_from_drop, desync_fifo_reset_flag_oe}, 8'hf);
    add_side_timing_select = 1'h1;
    cyc(4);
    chk(add_timing_from_drop, 8'h0);
    for (int m = 0; m < 2; m++) begin
      ds3_mode = m[0];
      tx_line_clk_present = 1'h0;
      cyc(30);
      chk({tx_prbs_use_alarm_clk, rx_prbs_use_alarm_clk}, 8'h2);
      tx_line_clk_present = 1'h1;
      rx_line_clk_present = 1'h0;
      cyc(30);
      chk({tx_prbs_use_alarm_clk, rx_prbs_use_alarm_clk}, 8'h1);
      rx_line_clk_present = 1'h1;
    end
    chk({ds3_ais_clock_ok, e3_ais_clock_ok}, 8'h3);
    run = 1'h0;
    cyc(30);
    chk({ds3_ais_clock_ok, e3_ais_clock_ok}, 8'h0);
  endtask : t_mode
  initial begin
    #10000;
    n_mismatch++;
    close_out;
  end
  initial begin
    cyc(4);
    srst = 1'h0;
    cyc(3);
    t_alarm;
    t_pulse;
    t_hrst;
    t_mode;
    close_out;
  end
endmodule : tb
